// ### lfm_pkg.sv
// Purpose: constants and types for the LED output fault monitor
// Assumes: 250 MHz sys_clk, registers reached over AHB-Lite
// Notes: analogue comparator results arrive as asynchronous levels
//
// Overview of operation
// - Ground-short check needs channel and global masks, output unlit over 5 us.
// - Qualified ground-short check: result 1 below open threshold, 0 above.
// - Short-fault flag sets when any channel reports a ground short.
// - Ground-short results and short-fault flag are readable by software.
// - Open check needs output, channel and global masks, output lit over 5 us.
// - Qualified open check: result 1 below open threshold, 0 above.
// - Open-fault flag sets when any channel reports open load.
// - Open results and open-fault flag are readable by software.
// - Adjacent check needs global mask and neighbours differing over 5 us.
// - Qualified adjacent check: result 1 above short threshold, 0 below.
// - Adjacent-fault flag sets on any adjacent short; results are readable.
// - Adjacent detection has no per-channel disable, only the global mask.
// - Threshold select 01 picks low threshold; 10 or 11 picks high one.
// - Supply fault flag follows sense comparator while checking is enabled.
// - Results and flags hold until the reset-status-flag command (supply flag only while disabled); the reset-event flag holds until the reset-POR command.
// - Warm flag sets above 125 C.
// - Hot flag sets and shutdown starts above 150 C.
// - Temperature flags stay set until the reset-status-flag command.
// - Shutdown forces all outputs off; leaves when sensor falls below 150 C.
// - Shutdown disable is accepted only right after the unlock command.
// - Hot flag still sets while shutdown is disabled.
// - Any system reset restores normal thermal shutdown.
// - Fault output pulled low on any summary, warm, reset-event or resistor fault.
package lfm_pkg;
   localparam int CHANNELS = 12;
   localparam int CLK_MHZ = 250;
   localparam int QUAL_TIME_US = 5;
   // Least time rounds up; exact here
   localparam int QUAL_CYCLES = QUAL_TIME_US * CLK_MHZ;
   localparam int QUAL_W = 11;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CHAN_MASK = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_GND_RESULT = 8'h10;
   localparam logic [7:0] OFS_OPEN_RESULT = 8'h14;
   localparam logic [7:0] OFS_ADJ_RESULT = 8'h18;
   // Command codes written to OFS_COMMAND
   localparam logic [7:0] CMD_RESET_STATUS = 8'h01;
   localparam logic [7:0] CMD_UNLOCK_TSD = 8'h02;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h03;
   localparam logic [7:0] CMD_RESET_POR = 8'h04;
   // Control field positions
   localparam int CTL_OUT_MASK = 0;     // 12 bits
   localparam int CTL_GND_GLOBAL = 12;
   localparam int CTL_OPEN_GLOBAL = 13;
   localparam int CTL_ADJ_GLOBAL = 14;
   localparam int CTL_SUP_SEL = 16;     // 2 bits
   localparam int CTL_TSD_DISABLE = 18;
   // Channel mask field positions
   localparam int CM_GND = 0;
   localparam int CM_OPEN = 16;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] CHAN_MASK_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [CHANNELS-1:0] outMask;
      logic gndGlobal;
      logic openGlobal;
      logic adjGlobal;
      logic [1:0] supSel;
   } lfm_ctrl_t;

   typedef struct packed {
      logic resetEvent;
      logic hotTemp;
      logic warmTemp;
      logic supplyFault;
      logic adjacentFault;
      logic openFault;
      logic shortFault;
   } lfm_status_t;
endpackage

// ### lfm_monitor.sv
// Purpose: per-channel fault qualification, temperature protection, AHB-Lite registers
// Assumes: comparator inputs asynchronous; ledOn from the same clock domain
// Notes: zero wait-state slave, responses always OKAY
`timescale 1ns/100ps
module lfm_monitor import lfm_pkg::*; (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic lowVoltageDetect,
   input wire logic [CHANNELS-1:0] ledOn,
   input wire logic [CHANNELS-1:0] outBelowOpenAsync,
   input wire logic [CHANNELS-1:0] diffAboveShortAsync,
   input wire logic senseBelowLowAsync,
   input wire logic senseBelowHighAsync,
   input wire logic tempAbove125Async,
   input wire logic tempAbove150Async,
   input wire logic resistorFault,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [CHANNELS-1:0] driverOutputsOff,
   output logic faultOut,
   output logic faultOutEn
);

   // Combined reset from pin and low-voltage detector; detector is async too
   logic sysReset_n;
   assign sysReset_n = reset_n & ~lowVoltageDetect;

   // Two-stage synchronisers for every comparator level
   localparam int SYN_W = 2 * CHANNELS + 4;
   logic [SYN_W-1:0] syncA_q;
   logic [SYN_W-1:0] syncB_q;
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= {outBelowOpenAsync, diffAboveShortAsync, senseBelowLowAsync,
                     senseBelowHighAsync, tempAbove125Async, tempAbove150Async};
         syncB_q <= syncA_q;
      end
   end
   logic [CHANNELS-1:0] outBelowOpen;
   logic [CHANNELS-1:0] diffAboveShort;
   logic senseBelowLow, senseBelowHigh, tempAbove125, tempAbove150;
   assign {outBelowOpen, diffAboveShort, senseBelowLow, senseBelowHigh,
           tempAbove125, tempAbove150} = syncB_q;

   // Saturating counter step shared by all qualification timers
   function automatic logic [QUAL_W-1:0] qualStep(input logic cond,
                                                  input logic [QUAL_W-1:0] cnt);
      if (!cond)
         qualStep = '0;
      else if (cnt == QUAL_W'(QUAL_CYCLES))
         qualStep = cnt;
      else
         qualStep = cnt + QUAL_W'(1);
   endfunction

   // Bus address phase capture
   logic wrPend_q, rdPend_q;
   logic [7:0] addr_q;
   logic busAct;
   assign busAct = hsel & hready & htrans[1];
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         addr_q <= '0;
      end else begin
         wrPend_q <= busAct & hwrite;
         rdPend_q <= busAct & ~hwrite;
         addr_q <= busAct ? haddr[7:0] : addr_q;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   logic wrControl, wrMask, wrCommand;
   assign wrControl = wrPend_q && addr_q == OFS_CONTROL;
   assign wrMask = wrPend_q && addr_q == OFS_CHAN_MASK;
   assign wrCommand = wrPend_q && addr_q == OFS_COMMAND;
   logic cmdResetStatus, cmdUnlock, cmdSoftReset, cmdResetPor;
   assign cmdResetStatus = wrCommand && hwdata[7:0] == CMD_RESET_STATUS;
   assign cmdUnlock = wrCommand && hwdata[7:0] == CMD_UNLOCK_TSD;
   assign cmdSoftReset = wrCommand && hwdata[7:0] == CMD_SOFT_RESET;
   assign cmdResetPor = wrCommand && hwdata[7:0] == CMD_RESET_POR;

   // Control and mask registers; soft reset keeps them per the retained set
   logic [31:0] control_q, chanMask_q;
   lfm_ctrl_t ctrl;
   assign ctrl.outMask = control_q[CTL_OUT_MASK +: CHANNELS];
   assign ctrl.gndGlobal = control_q[CTL_GND_GLOBAL];
   assign ctrl.openGlobal = control_q[CTL_OPEN_GLOBAL];
   assign ctrl.adjGlobal = control_q[CTL_ADJ_GLOBAL];
   assign ctrl.supSel = control_q[CTL_SUP_SEL +: 2];
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         control_q <= CONTROL_RESET;
         chanMask_q <= CHAN_MASK_RESET;
      end else begin
         if (wrControl)
            control_q <= {13'h0000, hwdata[18:0]} & ~(32'h1 << CTL_TSD_DISABLE);
         if (wrMask)
            chanMask_q <= hwdata;
      end
   end

   // Unlock arms for the next write only; disable cleared by any reset
   logic unlocked_q, tsdDisable_q;
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         unlocked_q <= 1'b0;
         tsdDisable_q <= 1'b0;
      end else begin
         if (cmdSoftReset)
            tsdDisable_q <= 1'b0;
         else if (wrControl && unlocked_q)
            tsdDisable_q <= hwdata[CTL_TSD_DISABLE];
         if (cmdUnlock)
            unlocked_q <= 1'b1;
         else if (wrPend_q)
            unlocked_q <= 1'b0;
      end
   end

   // Lit/unlit and neighbour-mismatch timers per channel
   logic [QUAL_W-1:0] litCnt_q [CHANNELS];
   logic [QUAL_W-1:0] unlitCnt_q [CHANNELS];
   logic [QUAL_W-1:0] adjCnt_q [CHANNELS];
   logic [CHANNELS-1:0] neighbourDiff;
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         neighbourDiff[i] = (i > 0 && ledOn[i] != ledOn[i-1]) ||
                            (i < CHANNELS-1 && ledOn[i] != ledOn[i+1]);
      end
   end
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            litCnt_q[i] <= '0;
            unlitCnt_q[i] <= '0;
            adjCnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            litCnt_q[i] <= qualStep(ledOn[i], litCnt_q[i]);
            unlitCnt_q[i] <= qualStep(~ledOn[i], unlitCnt_q[i]);
            adjCnt_q[i] <= qualStep(neighbourDiff[i], adjCnt_q[i]);
         end
      end
   end

   // Qualification: counter at ceiling means more than 5 us elapsed
   logic [CHANNELS-1:0] gndQual, openQual, adjQual;
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         gndQual[i] = ctrl.gndGlobal && chanMask_q[CM_GND + i] &&
                      unlitCnt_q[i] == QUAL_W'(QUAL_CYCLES);
         openQual[i] = ctrl.outMask[i] && chanMask_q[CM_OPEN + i] && ctrl.openGlobal &&
                       litCnt_q[i] == QUAL_W'(QUAL_CYCLES);
         adjQual[i] = ctrl.adjGlobal && adjCnt_q[i] == QUAL_W'(QUAL_CYCLES);
      end
   end

   // Result bits follow comparators while qualified, else hold until the clear command
   logic [CHANNELS-1:0] gndRes_q, openRes_q, adjRes_q;
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         gndRes_q <= '0;
         openRes_q <= '0;
         adjRes_q <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (gndQual[i])
               gndRes_q[i] <= outBelowOpen[i];
            else if (cmdResetStatus)
               gndRes_q[i] <= 1'b0;
            if (openQual[i])
               openRes_q[i] <= outBelowOpen[i];
            else if (cmdResetStatus)
               openRes_q[i] <= 1'b0;
            if (adjQual[i])
               adjRes_q[i] <= diffAboveShort[i];
            else if (cmdResetStatus)
               adjRes_q[i] <= 1'b0;
         end
      end
   end

   // Supply check: field 00 disables; bit 16 alone picks the low threshold, else high
   logic supEnable, supBelow;
   assign supEnable = ctrl.supSel != 2'b00;
   assign supBelow = (ctrl.supSel == 2'b01) ? senseBelowLow : senseBelowHigh;

   // Sticky status; hardware set wins over the clear command
   lfm_status_t status_q;
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         status_q <= '1; // Flags read as set after a hard reset
      end else begin
         status_q.shortFault <= (|gndRes_q) | (status_q.shortFault & ~cmdResetStatus);
         status_q.openFault <= (|openRes_q) | (status_q.openFault & ~cmdResetStatus);
         status_q.adjacentFault <= (|adjRes_q) |
                                   (status_q.adjacentFault & ~cmdResetStatus);
         if (supEnable)
            status_q.supplyFault <= supBelow;
         else if (cmdResetStatus)
            status_q.supplyFault <= 1'b0;
         status_q.warmTemp <= tempAbove125 | (status_q.warmTemp & ~cmdResetStatus);
         status_q.hotTemp <= tempAbove150 | (status_q.hotTemp & ~cmdResetStatus);
         status_q.resetEvent <= cmdSoftReset | (status_q.resetEvent & ~cmdResetPor);
      end
   end

   // Shutdown follows live sensor, so it ends when the die cools
   logic shutdown;
   assign shutdown = tempAbove150 & ~tsdDisable_q;
   assign driverOutputsOff = {CHANNELS{shutdown}};

   // Open-drain fault pin: drive low a cycle after any flag other than the hot flag, or the resistor fault, is set
   logic faultEn_q;
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n)
         faultEn_q <= 1'b1;
      else
         faultEn_q <= status_q.shortFault | status_q.openFault | status_q.adjacentFault |
                      status_q.supplyFault | status_q.warmTemp | status_q.resetEvent |
                      resistorFault;
   end
   assign faultOut = 1'b0;
   assign faultOutEn = faultEn_q;

   // Read data registered at address phase for a zero-wait answer
   always_ff @(posedge sys_clk or negedge sysReset_n) begin
      if (!sysReset_n) begin
         hrdata <= '0;
      end else if (busAct & ~hwrite) begin
         unique case (haddr[7:0])
            OFS_CONTROL: hrdata <= control_q | (32'(tsdDisable_q) << CTL_TSD_DISABLE);
            OFS_CHAN_MASK: hrdata <= chanMask_q;
            OFS_STATUS: hrdata <= {25'h000_0000, status_q};
            OFS_GND_RESULT: hrdata <= {20'h0_0000, gndRes_q};
            OFS_OPEN_RESULT: hrdata <= {20'h0_0000, openRes_q};
            OFS_ADJ_RESULT: hrdata <= {20'h0_0000, adjRes_q};
            default: hrdata <= '0;
         endcase
      end
   end

   // Shutdown must track the hot sensor with the disable bit
   shutdown_track_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      driverOutputsOff[0] == (tempAbove150 && !tsdDisable_q))
      else $error("shutdown does not follow sensor");
   // Disable may only rise in the cycle after an unlocked write
   tsd_unlock_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      $rose(tsdDisable_q) |-> $past(unlocked_q) && $past(wrControl))
      else $error("shutdown disabled without unlock");
   // Hot flag is set a cycle after the sensor, disabled or not
   hot_flag_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      tempAbove150 |=> status_q.hotTemp)
      else $error("hot flag missed");
   warm_flag_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      tempAbove125 |=> status_q.warmTemp)
      else $error("warm flag missed");
   // Sticky temperature flag only falls on the clear command
   temp_hold_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      $fell(status_q.warmTemp) |-> $past(cmdResetStatus))
      else $error("warm flag dropped without clear");
   short_flag_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      (|gndRes_q) |=> status_q.shortFault)
      else $error("short flag missed");
   open_flag_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      (|openRes_q) |=> status_q.openFault)
      else $error("open flag missed");
   // Ground result updates one cycle after a qualified compare
   gnd_result_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      gndQual[0] |=> gndRes_q[0] == $past(outBelowOpen[0]))
      else $error("ground result wrong");
   // Open result may only change while qualified or on clear
   open_hold_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      !openQual[0] && !cmdResetStatus |=> $stable(openRes_q[0]))
      else $error("open result changed unqualified");
   // Adjacent result needs the global mask and a neighbour mismatch
   adj_qual_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      $rose(adjRes_q[1]) |-> $past(ctrl.adjGlobal) && $past(neighbourDiff[1]))
      else $error("adjacent result without qualification");
   fault_pin_a: assert property (@(posedge sys_clk) disable iff (!sysReset_n)
      status_q.warmTemp |=> faultOutEn)
      else $error("fault pin not driven");

endmodule // lfm_monitor

// ### lfm_analog_model.sv
// Purpose: analogue front end that feeds the fault monitor comparators
// Assumes: fault vectors chosen by the bench, one bit per channel
// Notes: outputs lag by a fraction of a cycle so they never land on a clock edge
`timescale 1ns/100ps
module lfm_analog_model import lfm_pkg::*; (
   input wire logic [CHANNELS-1:0] ledOn,
   input wire logic [CHANNELS-1:0] driverOutputsOff,
   input wire logic [CHANNELS-1:0] gndShort,
   input wire logic [CHANNELS-1:0] openLoad,
   input wire logic [CHANNELS-1:0] adjShort,
   output logic [CHANNELS-1:0] outBelowOpenAsync,
   output logic [CHANNELS-1:0] diffAboveShortAsync
);
   // Lit pin sags on open load, unlit pin sits low on ground short
   // A pin forced off floats up, so it never looks open while off
   assign #(1.3) outBelowOpenAsync = (ledOn & ~driverOutputsOff & openLoad) | (~ledOn & gndShort);
   // Difference comparator passes the injected short as is
   assign #(1.7) diffAboveShortAsync = adjShort;
endmodule // lfm_analog_model

// ### testbench.sv
// Purpose: self-checking bench for the LED output fault monitor
// Assumes: one 250 MHz clock, AHB-Lite single word transfers, zero wait states
// Notes: faults and masks are random from a fixed seed; each case waits out qualification
`timescale 1ns/100ps
module testbench import lfm_pkg::*;;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic lowVoltageDetect = 1'b0;
   logic [CHANNELS-1:0] ledOn = '0, gndShort = '0, openLoad = '0, adjShort = '0;
   logic senseBelowLow = 1'b0, senseBelowHigh = 1'b0, temp125 = 1'b0, temp150 = 1'b0;
   logic resistorFault = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp, faultOut, faultOutEn;
   logic [CHANNELS-1:0] driverOutputsOff, outBelowOpen, diffAboveShort;
   int mismatches = 0, samplesChecked = 0, cycles = 0;
   logic [31:0] seed = 32'h7a48_c071;
   logic [11:0] ledTbl [4] = '{12'h000, 12'hFFF, 12'h555, 12'hAAA};

   // Free running clock, 4 ns period
   always #2 sys_clk = ~sys_clk;

   lfm_analog_model lfm_analog_model_i (.ledOn(ledOn), .driverOutputsOff(driverOutputsOff),
      .gndShort(gndShort), .openLoad(openLoad), .adjShort(adjShort),
      .outBelowOpenAsync(outBelowOpen), .diffAboveShortAsync(diffAboveShort));
   lfm_monitor lfm_monitor_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .lowVoltageDetect(lowVoltageDetect), .ledOn(ledOn), .outBelowOpenAsync(outBelowOpen),
      .diffAboveShortAsync(diffAboveShort), .senseBelowLowAsync(senseBelowLow),
      .senseBelowHighAsync(senseBelowHigh), .tempAbove125Async(temp125),
      .tempAbove150Async(temp150), .resistorFault(resistorFault), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .driverOutputsOff(driverOutputsOff),
      .faultOut(faultOut), .faultOutEn(faultOutEn));

   task automatic summarize();
      if (mismatches == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard, well above the roughly eight thousand cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end

   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Per channel results: ground short on unlit, open on lit, adjacent where a neighbour differs
   function automatic logic [35:0] expRes(input logic [11:0] led, input logic [31:0] ctl,
         input logic [31:0] cm);
      logic [11:0] diff;
      diff = (led ^ {led[10:0], led[0]}) | (led ^ {led[11], led[11:1]});
      return {ctl[12] ? ~led & cm[11:0] & gndShort : 12'h000,
         ctl[13] ? led & ctl[11:0] & cm[27:16] & openLoad : 12'h000,
         ctl[14] ? diff & adjShort : 12'h000};
   endfunction

   // Low select compares against the low threshold, other codes the high one
   function automatic logic expSup(input logic [1:0] sel, input logic lo, input logic hi);
      return (sel == 2'b01) ? lo : hi;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One transfer; entered just after an edge, request held until hready is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(name, e & m, r & m);
   endtask

   task automatic cmd(input logic [7:0] c);
      wr(OFS_COMMAND, {24'h00_0000, c});
   endtask

   // Random masks and faults, clear, read mask back, wait out qualification, read results and status back
   task automatic runCase(input logic [11:0] led, input logic [2:0] glob);
      logic [31:0] ctl, cm;
      logic [35:0] e;
      seed = nextRand(seed);
      ctl = {17'h0_0000, glob, seed[11:0]};
      cm = {4'h0, seed[27:16], 4'h0, seed[23:12]};
      seed = nextRand(seed);
      gndShort <= seed[11:0];
      openLoad <= seed[27:16];
      adjShort <= seed[23:12] ^ seed[11:0];
      ledOn <= led;
      wr(OFS_CONTROL, ctl);
      wr(OFS_CHAN_MASK, cm);
      // Two clears: set wins, so the first can lose to results left from the last case
      cmd(CMD_RESET_STATUS);
      cmd(CMD_RESET_STATUS);
      rd("chanMask", OFS_CHAN_MASK, 32'hFFFF_FFFF, cm);
      tick(QUAL_CYCLES + 20);
      e = expRes(led, ctl, cm);
      rd("gnd", OFS_GND_RESULT, 32'h0000_0FFF, {20'h0_0000, e[35:24]});
      rd("open", OFS_OPEN_RESULT, 32'h0000_0FFF, {20'h0_0000, e[23:12]});
      rd("adj", OFS_ADJ_RESULT, 32'h0000_0FFF, {20'h0_0000, e[11:0]});
      rd("status", OFS_STATUS, 32'h0000_007F,
         {29'h0000_0000, |e[11:0], |e[23:12], |e[35:24]});
      tick(2);
      chk("faultEn", {31'h0000_0000, |e}, {31'h0000_0000, faultOutEn});
   endtask

   // Shutdown state on the pins and temperature flags in the status word
   task automatic tcheck(input logic [11:0] off, input logic [31:0] st);
      tick(8);
      chk("off", {20'h0_0000, off}, {20'h0_0000, driverOutputsOff});
      rd("temp", OFS_STATUS, 32'h0000_0030, st);
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      // Reset state, read-only status, unmapped word
      chk("pins", 32'h0000_0000, {30'h0000_0000, hresp, faultOut});
      rd("status", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_007F);
      for (int k = 0; k < 4; k++) rd("result", 8'h10 + 8'(4 * k), 32'hFFFF_FFFF, 32'h0);
      chk("faultEn", 32'h0000_0001, {31'h0000_0000, faultOutEn});
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      rd("status", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_007F);
      cmd(CMD_RESET_STATUS);
      cmd(CMD_RESET_POR);
      rd("status", OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
      tick(4);
      chk("faultEn", 32'h0000_0000, {31'h0000_0000, faultOutEn});
      resistorFault <= 1'b1;
      tick(4);
      chk("faultEn", 32'h0000_0001, {31'h0000_0000, faultOutEn});
      resistorFault <= 1'b0;
      // Gating by lit state and global masks
      for (int i = 0; i < 6; i++) runCase(ledTbl[i % 4], (i < 4) ? 3'b111 : 3'(i));
      // Every supply threshold code with random comparator levels
      for (int i = 0; i < 6; i++) begin
         seed = nextRand(seed);
         senseBelowLow <= seed[0];
         senseBelowHigh <= seed[1];
         wr(OFS_CONTROL, {14'h0000, 2'(i % 3 + 1), 16'h0000});
         tick(8);
         rd("supply", OFS_STATUS, 32'h0000_0008,
            {28'h000_0000, expSup(2'(i % 3 + 1), seed[0], seed[1]), 3'h0});
      end
      // Temperature levels, sticky flags, shutdown and its guarded disable
      wr(OFS_CONTROL, 32'h0000_0000);
      temp125 <= 1'b1;
      tick(8);
      rd("warm", OFS_STATUS, 32'h0000_0030, 32'h0000_0010);
      chk("faultEn", 32'h0000_0001, {31'h0000_0000, faultOutEn});
      temp150 <= 1'b1;
      tcheck(12'hFFF, 32'h0000_0030);
      temp125 <= 1'b0;
      temp150 <= 1'b0;
      tcheck(12'h000, 32'h0000_0030);
      cmd(CMD_RESET_STATUS);
      tcheck(12'h000, 32'h0000_0000);
      wr(OFS_CONTROL, 32'h0004_0000);
      rd("tsdOff", OFS_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000);
      temp150 <= 1'b1;
      tcheck(12'hFFF, 32'h0000_0020);
      temp150 <= 1'b0;
      tick(8);
      cmd(CMD_RESET_STATUS);
      cmd(CMD_UNLOCK_TSD);
      wr(OFS_CONTROL, 32'h0004_0000);
      rd("tsdOn", OFS_CONTROL, 32'hFFFF_FFFF, 32'h0004_0000);
      temp150 <= 1'b1;
      tcheck(12'h000, 32'h0000_0020);
      cmd(CMD_SOFT_RESET);
      tcheck(12'hFFF, 32'h0000_0020);
      rd("event", OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
      cmd(CMD_UNLOCK_TSD);
      wr(OFS_CONTROL, 32'h0004_0000);
      tcheck(12'h000, 32'h0000_0020);
      lowVoltageDetect <= 1'b1;
      tick(2);
      lowVoltageDetect <= 1'b0;
      tcheck(12'hFFF, 32'h0000_0030);
      summarize();
   end
endmodule // testbench
